// file: rtl/lrac_pkg.sv
package lrac_pkg;
  // Clock rate and the one-second tick used for all settable times
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_TIME_S = 1;
  localparam int TICK_CYCLES = TICK_TIME_S * CLK_HZ;

  // Register indexes on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LOWER = 4'h1;
  localparam logic [3:0] ADDR_UPPER = 4'h2;
  localparam logic [3:0] ADDR_AUX_TIME = 4'h3;
  localparam logic [3:0] ADDR_FLUSH_TIME = 4'h4;
  localparam logic [3:0] ADDR_ERR_CFG = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_FIRST_CURRENT_OUTPUT = 4'h7;
  localparam logic [3:0] ADDR_OUT2 = 4'h8;
  localparam logic [3:0] ADDR_FLOW_LO = 4'h9;
  localparam logic [3:0] ADDR_FLOW_HI = 4'hA;
  localparam logic [3:0] ADDR_CMD = 4'hB;

  // Control and command register field positions
  localparam int CTRL_THR_LSB = 0;
  localparam int CTRL_LCNT_LSB = 2;
  localparam int CTRL_UCNT_LSB = 4;
  localparam int CTRL_AUX_LSB = 6;
  localparam int CTRL_PNT_LSB = 9;
  localparam int CTRL_METER_LSB = 11;
  localparam int CMD_ACK_BIT = 0;
  localparam int CMD_START_BIT = 1;

  // Values after reset
  localparam logic [15:0] CTRL_RESET = 16'h2014;
  localparam logic [15:0] LOWER_RESET = 16'h0000;
  localparam logic [15:0] UPPER_RESET = 16'h0100;
  localparam logic [15:0] AUX_TIME_RESET = 16'h0000;
  localparam logic [15:0] FLUSH_TIME_RESET = 16'h0000;
  localparam logic [15:0] ERR_CFG_RESET = 16'hAAAA;

  // Flow-meter constants in tenths of a litre per pulse
  localparam logic [15:0] METER_1L = 16'h000A;
  localparam logic [15:0] METER_2L5 = 16'h0019;
  localparam logic [15:0] METER_5L = 16'h0032;
  localparam logic [15:0] METER_10L = 16'h0064;
  localparam logic [15:0] METER_100L = 16'h03E8;
  localparam logic [15:0] METER_500L = 16'h1388;
  localparam logic [15:0] METER_1000L = 16'h2710;

  localparam int NUM_ERR = 8;

  typedef enum logic [1:0] {
    THR_LIMIT, THR_TWO_POINT, THR_RANGE, THR_SPARE
  } lrac_thr_mode_t;

  typedef enum logic [2:0] {
    AUX_OFF, AUX_BEFORE_RETRY, AUX_BEFORE, AUX_DURING,
    AUX_BEFORE_DURING, AUX_AFTER
  } lrac_aux_mode_t;

  typedef enum logic [1:0] {
    PNT_SINGLE, PNT_ALTERNATE, PNT_INPUT
  } lrac_point_mode_t;

  // Per-error signalling
  typedef enum logic [1:0] {
    SIG_NONE, SIG_MESSAGE, SIG_ALARM, SIG_ALARM2
  } lrac_sig_t;
endpackage

// file: rtl/lrac_channel.sv
`timescale 1ns/10ps
`default_nettype none
module lrac_channel (
  input wire logic clk,
  input wire logic resetn,
  input wire logic is_upper,
  input wire lrac_pkg::lrac_thr_mode_t mode,
  input wire logic [1:0] count_set,
  input wire logic [15:0] lower,
  input wire logic [15:0] upper,
  input wire logic [15:0] value,
  input wire logic eval,
  output logic relay,
  output logic led_red,
  output logic led_green,
  output logic want_retry
);
  import lrac_pkg::*;

  logic viol;
  logic release_ok;
  logic [1:0] need;
  logic [1:0] cnt_q;
  logic [1:0] cnt_inc;

  // Violation and release per mode; a setting of zero acts as one
  always_comb begin
    need = (count_set == 2'h0) ? 2'h1 : count_set;
    cnt_inc = cnt_q + 2'h1;
    case (mode)
      THR_TWO_POINT: begin
        viol = is_upper ? (value > upper) : (value > lower);
        release_ok = is_upper ? (value < lower) : !viol;
      end
      THR_RANGE: begin
        viol = is_upper ? (value > upper) : (value < lower);
        release_ok = !viol;
      end
      default: begin
        viol = is_upper ? (value > upper) : (value > lower);
        release_ok = !viol;
      end
    endcase
  end

  // Counting only advances on a result strobe; held while relay is on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 2'h0;
      relay <= 1'b0;
      want_retry <= 1'b0;
    end else if (eval) begin
      want_retry <= 1'b0;
      if (relay) begin
        if (release_ok) begin
          relay <= 1'b0;
          cnt_q <= 2'h0;
        end
      end else if (viol) begin
        if (cnt_inc >= need) begin
          relay <= 1'b1;
        end else begin
          cnt_q <= cnt_inc;
          want_retry <= 1'b1;
        end
      end else begin
        cnt_q <= 2'h0; // Breaks a run of consecutive results
      end
    end
  end

  // Indicator follows the relay state exactly
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      led_red <= 1'b0;
      led_green <= 1'b1;
    end else if (eval) begin
      led_red <= relay ? !release_ok : (viol && cnt_inc >= need);
      led_green <= relay ? release_ok : !(viol && cnt_inc >= need);
    end
  end
endmodule
`default_nettype wire

// file: rtl/lrac_top.sv
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module lrac_top #(
  parameter int TICK_LEN = lrac_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic analysis_request,
  input wire logic result_valid,
  input wire logic [15:0] result_value,
  input wire logic flow_pulse_input,
  input wire logic sample_point_select_input,
  input wire logic [lrac_pkg::NUM_ERR-1:0] error_in,
  input wire logic external_acknowledge_input,
  output logic analysis_go,
  output logic sample_point,
  output logic inlet_valve,
  output logic outlet_valve,
  output logic aux_relay,
  output logic lower_threshold_relay,
  output logic upper_threshold_relay,
  output logic lower_led_red,
  output logic lower_led_green,
  output logic upper_led_red,
  output logic upper_led_green,
  output logic fault_relay,
  output logic error_message,
  output logic [15:0] first_current_output,
  output logic [15:0] second_current_output
);
  import lrac_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_AUX_PRE, ST_FLUSH, ST_RUN, ST_EVAL, ST_AUX_POST
  } lrac_state_t;

  logic [15:0] ctrl_q;
  logic [15:0] lower_q;
  logic [15:0] upper_q;
  logic [15:0] aux_time_q;
  logic [15:0] flush_time_q;
  logic [15:0] err_cfg_q;
  logic [31:0] flow_q;
  lrac_state_t state_q;
  lrac_state_t state_d;
  logic [31:0] tick_q;
  logic [15:0] sec_q;
  logic start_pend_q;
  logic retry_pend_q;
  logic retry_run_q;
  logic alt_q;
  logic flow_prev_q;
  logic external_acknowledge_input_prev_q;
  logic [NUM_ERR-1:0] err_prev_q;
  logic [NUM_ERR-1:0] alarm_q;
  logic [NUM_ERR-1:0] alarm_d;
  logic [NUM_ERR-1:0] cfg_alarm;
  logic [NUM_ERR-1:0] cfg_msg;
  lrac_thr_mode_t thr_mode;
  lrac_aux_mode_t aux_mode;
  lrac_point_mode_t pnt_mode;
  logic [2:0] meter_sel;
  logic [15:0] meter_step;
  logic wr_cmd;
  logic ack;
  logic take;
  logic aux_en;
  logic pre_needed;
  logic post_needed;
  logic eval;
  logic next_point;
  logic lower_retry;
  logic upper_retry;
  logic [15:0] upper_m1;

  // Field views of the control register
  assign thr_mode = lrac_thr_mode_t'(ctrl_q[CTRL_THR_LSB +: 2]);
  assign aux_mode = lrac_aux_mode_t'(ctrl_q[CTRL_AUX_LSB +: 3]);
  assign pnt_mode = lrac_point_mode_t'(ctrl_q[CTRL_PNT_LSB +: 2]);
  assign meter_sel = ctrl_q[CTRL_METER_LSB +: 3];
  assign wr_cmd = reg_wr && (reg_addr == ADDR_CMD);
  assign eval = (state_q == ST_RUN) && result_valid;

  // Aux relay only takes part with a nonzero time and an active mode
  assign aux_en = (aux_time_q != 16'h0000) && (aux_mode != AUX_OFF);
  assign pre_needed = aux_en && ((aux_mode == AUX_BEFORE) ||
    (aux_mode == AUX_BEFORE_DURING) ||
    ((aux_mode == AUX_BEFORE_RETRY) && retry_pend_q));
  assign post_needed = aux_en && (aux_mode == AUX_AFTER);
  assign take = (state_q == ST_IDLE) && (start_pend_q || retry_pend_q);

  // Retries keep the point in alternate mode only; fresh analyses pick it by mode
  always_comb begin
    case (pnt_mode)
      PNT_ALTERNATE: next_point = retry_pend_q ? sample_point : alt_q;
      PNT_INPUT: next_point = sample_point_select_input;
      default: next_point = 1'b0;
    endcase
  end

  // Sequencer: optional aux lead, flush, analysis, optional aux tail
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = pre_needed ? ST_AUX_PRE : ST_FLUSH;
        end
      end
      ST_AUX_PRE: begin
        if (sec_q >= aux_time_q) begin
          state_d = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (sec_q >= flush_time_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (result_valid) begin
          state_d = ST_EVAL;
        end
      end
      ST_EVAL: begin
        state_d = post_needed ? ST_AUX_POST : ST_IDLE;
      end
      ST_AUX_POST: begin
        if (sec_q >= aux_time_q) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Seconds counter restarts on every phase change
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_q <= 32'h0;
      sec_q <= 16'h0;
    end else if (state_d != state_q) begin
      tick_q <= 32'h0;
      sec_q <= 16'h0;
    end else if (tick_q == 32'(TICK_LEN - 1)) begin
      tick_q <= 32'h0;
      if (sec_q != 16'hFFFF) begin
        sec_q <= sec_q + 16'h1;
      end
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // Triggers seen while busy wait here, which stretches the interval
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_pend_q <= 1'b0;
      retry_pend_q <= 1'b0;
      retry_run_q <= 1'b0;
    end else begin
      if (analysis_request || (wr_cmd && reg_wdata[CMD_START_BIT])) begin
        start_pend_q <= 1'b1;
      end else if (take && !retry_pend_q) begin
        start_pend_q <= 1'b0;
      end
      if (state_q == ST_EVAL) begin
        retry_pend_q <= lower_retry || upper_retry;
      end else if (take) begin
        retry_pend_q <= 1'b0;
      end
      if (take) begin
        retry_run_q <= retry_pend_q;
      end
    end
  end

  // Sampling point choice and alternation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_point <= 1'b0;
      alt_q <= 1'b0;
    end else if (take) begin
      sample_point <= next_point;
      if (pnt_mode == PNT_ALTERNATE && !retry_pend_q) begin
        alt_q <= !alt_q;
      end
    end
  end

  // Results go to the output of the point they were taken from
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_current_output <= 16'h0;
      second_current_output <= 16'h0;
    end else if (eval) begin
      if (!sample_point) begin
        first_current_output <= result_value;
      end else begin
        second_current_output <= result_value;
      end
    end
  end

  // Phase-driven outputs, registered from the next state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analysis_go <= 1'b0;
      inlet_valve <= 1'b0;
      outlet_valve <= 1'b0;
      aux_relay <= 1'b0;
    end else begin
      analysis_go <= (state_d == ST_RUN) && (state_q != ST_RUN);
      inlet_valve <= state_d == ST_FLUSH;
      outlet_valve <= state_d == ST_FLUSH;
      aux_relay <= aux_en && ((state_d == ST_AUX_PRE) ||
        (state_d == ST_AUX_POST) || ((state_d == ST_RUN) &&
        ((aux_mode == AUX_DURING) ||
        (aux_mode == AUX_BEFORE_DURING))));
    end
  end

  lrac_channel u_lower (
    .clk(clk),
    .resetn(resetn),
    .is_upper(1'b0),
    .mode(thr_mode),
    .count_set(ctrl_q[CTRL_LCNT_LSB +: 2]),
    .lower(lower_q),
    .upper(upper_q),
    .value(result_value),
    .eval(eval),
    .relay(lower_threshold_relay),
    .led_red(lower_led_red),
    .led_green(lower_led_green),
    .want_retry(lower_retry)
  );

  lrac_channel u_upper (
    .clk(clk),
    .resetn(resetn),
    .is_upper(1'b1),
    .mode(thr_mode),
    .count_set(ctrl_q[CTRL_UCNT_LSB +: 2]),
    .lower(lower_q),
    .upper(upper_q),
    .value(result_value),
    .eval(eval),
    .relay(upper_threshold_relay),
    .led_red(upper_led_red),
    .led_green(upper_led_green),
    .want_retry(upper_retry)
  );

  // Meter constant in tenths of a litre so 2.5 l stays exact
  always_comb begin
    case (meter_sel)
      3'h0: meter_step = METER_1L;
      3'h1: meter_step = METER_2L5;
      3'h2: meter_step = METER_5L;
      3'h3: meter_step = METER_10L;
      3'h5: meter_step = METER_500L;
      3'h6: meter_step = METER_1000L;
      default: meter_step = METER_100L;
    endcase
  end

  // Rising pulse edges accumulate volume; a pulse during a clear leaves one meter step
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flow_prev_q <= 1'b0;
      flow_q <= 32'h0;
    end else begin
      flow_prev_q <= flow_pulse_input;
      if (flow_pulse_input && !flow_prev_q) begin
        if (reg_wr && (reg_addr == ADDR_FLOW_LO ||
            reg_addr == ADDR_FLOW_HI)) begin
          flow_q <= {16'h0, meter_step};
        end else begin
          flow_q <= flow_q + {16'h0, meter_step};
        end
      end else if (reg_wr && (reg_addr == ADDR_FLOW_LO ||
          reg_addr == ADDR_FLOW_HI)) begin
        flow_q <= 32'h0;
      end
    end
  end

  // Error routing: threshold results never reach this path
  always_comb begin
    ack = (wr_cmd && reg_wdata[CMD_ACK_BIT]) ||
      (external_acknowledge_input && !external_acknowledge_input_prev_q);
    for (int i = 0; i < NUM_ERR; i++) begin
      cfg_alarm[i] = err_cfg_q[2*i+1];
      cfg_msg[i] = err_cfg_q[2*i+1 -: 2] != 2'h0;
      if (error_in[i] && !err_prev_q[i] && cfg_alarm[i]) begin
        alarm_d[i] = 1'b1; // New error beats a same-cycle acknowledge
      end else if (ack || !error_in[i] || !cfg_alarm[i]) begin
        alarm_d[i] = 1'b0;
      end else begin
        alarm_d[i] = alarm_q[i];
      end
    end
  end

  // Fault relay is energised when healthy, so a dead supply reads as fault
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_prev_q <= '0;
      alarm_q <= '0;
      external_acknowledge_input_prev_q <= 1'b0;
      fault_relay <= 1'b0;
      error_message <= 1'b0;
    end else begin
      err_prev_q <= error_in;
      alarm_q <= alarm_d;
      external_acknowledge_input_prev_q <= external_acknowledge_input;
      fault_relay <= !(|alarm_d);
      error_message <= |(error_in & cfg_msg);
    end
  end

  assign upper_m1 = (upper_q == 16'h0) ? 16'h0 : upper_q - 16'h1;

  // Register writes; lower is clamped below upper on either write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RESET;
      lower_q <= LOWER_RESET;
      upper_q <= UPPER_RESET;
      aux_time_q <= AUX_TIME_RESET;
      flush_time_q <= FLUSH_TIME_RESET;
      err_cfg_q <= ERR_CFG_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: ctrl_q <= reg_wdata;
        ADDR_LOWER: begin
          lower_q <= (reg_wdata >= upper_q) ? upper_m1 : reg_wdata;
        end
        ADDR_UPPER: begin
          upper_q <= reg_wdata;
          if (reg_wdata <= lower_q) begin
            lower_q <= (reg_wdata == 16'h0) ? 16'h0 :
              reg_wdata - 16'h1;
          end
        end
        ADDR_AUX_TIME: aux_time_q <= reg_wdata;
        ADDR_FLUSH_TIME: flush_time_q <= reg_wdata;
        ADDR_ERR_CFG: err_cfg_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= ctrl_q;
        ADDR_LOWER: reg_rdata <= lower_q;
        ADDR_UPPER: reg_rdata <= upper_q;
        ADDR_AUX_TIME: reg_rdata <= aux_time_q;
        ADDR_FLUSH_TIME: reg_rdata <= flush_time_q;
        ADDR_ERR_CFG: reg_rdata <= err_cfg_q;
        ADDR_STATUS: reg_rdata <= {alarm_q, retry_run_q,
          state_q, sample_point, !fault_relay, upper_threshold_relay,
          lower_threshold_relay};
        ADDR_FIRST_CURRENT_OUTPUT: reg_rdata <= first_current_output;
        ADDR_OUT2: reg_rdata <= second_current_output;
        ADDR_FLOW_LO: reg_rdata <= flow_q[15:0];
        ADDR_FLOW_HI: reg_rdata <= flow_q[31:16];
        default: reg_rdata <= 16'h0;
      endcase
    end else begin
      reg_rdata <= 16'h0;
    end
  end
endmodule
`default_nettype wire

// file: dv/lrac_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module lrac_seq_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic analysis_go,
  input wire logic [15:0] meas_value,
  input wire logic [3:0] meas_delay,
  output logic result_valid,
  output logic [15:0] result_value
);
  logic busy_q;
  logic [3:0] cnt_q;
  // One result strobe per analysis, after a delay set by the bench
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      result_valid <= 1'b0;
      result_value <= 16'h0000;
    end else begin
      result_valid <= 1'b0;
      result_value <= ~result_value; // Stale data must never look usable
      if (analysis_go) begin
        busy_q <= 1'b1;
        cnt_q <= meas_delay;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        result_valid <= 1'b1;
        result_value <= meas_value;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/lrac_props.sv
`timescale 1ns/10ps
`default_nettype none
module lrac_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic result_valid,
  input wire logic [lrac_pkg::NUM_ERR-1:0] error_in,
  input wire logic external_acknowledge_input,
  input wire logic analysis_go,
  input wire logic inlet_valve,
  input wire logic outlet_valve,
  input wire logic aux_relay,
  input wire logic lower_threshold_relay,
  input wire logic upper_threshold_relay,
  input wire logic lower_led_red,
  input wire logic lower_led_green,
  input wire logic upper_led_red,
  input wire logic upper_led_green,
  input wire logic fault_relay
);
  import lrac_pkg::*;
  logic aux_zero_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Mirror of a zero auxiliary on-time, reset value is zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aux_zero_q <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_AUX_TIME) begin
      aux_zero_q <= reg_wdata == 16'h0000;
    end
  end
  a_lower_red_relay: assert property (
    lower_led_red == lower_threshold_relay) else $error("lower red bad");
  a_upper_red_relay: assert property (
    upper_led_red == upper_threshold_relay) else $error("upper red bad");
  a_green_not_red: assert property (
    lower_led_green != lower_led_red && upper_led_green != upper_led_red)
    else $error("green and red indicators agree");
  a_valves_together: assert property (
    inlet_valve == outlet_valve) else $error("valves differ");
  a_flush_then_go: assert property (
    $fell(inlet_valve) |-> analysis_go) else $error("no go after flush");
  a_relay_on_result: assert property (
    $rose(lower_threshold_relay) || $rose(upper_threshold_relay)
    |-> $past(result_valid)) else $error("relay rose without result");
  a_go_one_cycle: assert property (
    analysis_go |=> !analysis_go) else $error("go longer than a cycle");
  a_aux_zero_idle: assert property (
    aux_zero_q && $past(aux_zero_q) |-> !aux_relay)
    else $error("aux active with zero time");
  a_fault_needs_err: assert property (
    $fell(fault_relay) |-> $past(|error_in)) else $error("alarm w/o error");
  a_fault_holds: assert property (
    !fault_relay && (|error_in) && $stable(error_in) && !reg_wr
    && !$past(reg_wr) && !external_acknowledge_input
    && !$past(external_acknowledge_input) |=> !fault_relay)
    else $error("alarm dropped while error persists");
  a_ack_clears: assert property (
    $rose(external_acknowledge_input) && !fault_relay && $stable(error_in)
    |-> ##[1:4] fault_relay) else $error("ack did not end alarm");
  cover property ($rose(upper_threshold_relay));
  cover property ($fell(fault_relay));
  cover property ($rose(aux_relay));
endmodule
bind lrac_top lrac_props u_props (
  .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .result_valid, .error_in,
  .external_acknowledge_input, .analysis_go, .inlet_valve, .outlet_valve,
  .aux_relay, .lower_threshold_relay, .upper_threshold_relay,
  .lower_led_red, .lower_led_green, .upper_led_red, .upper_led_green,
  .fault_relay
);
`default_nettype wire

// file: dv/tb_limit_relay_alarm_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_limit_relay_alarm_control;
  import lrac_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, analysis_request, result_valid;
  logic flow_pulse_input, sample_point_select_input, error_message;
  logic external_acknowledge_input, analysis_go, sample_point, inlet_valve;
  logic outlet_valve, aux_relay, lower_threshold_relay, upper_threshold_relay;
  logic lower_led_red, lower_led_green, upper_led_red, upper_led_green;
  logic fault_relay, last_pt, aux_d, p;
  logic [3:0] reg_addr, meas_delay;
  logic [15:0] reg_wdata, reg_rdata, result_value, meas_value, rv;
  logic [15:0] first_current_output, second_current_output;
  logic [NUM_ERR-1:0] error_in;
  int err_total, comparisons, gos, rises, vcyc, aux_n, v_n;
  int kpp [7] = '{10, 25, 50, 100, 1000, 5000, 10000};
  logic [15:0] sv [10] = '{16'h0020, 16'h0040, 16'h0005, 16'h0040, 16'h0020,
    16'h0008, 16'h0008, 16'h0020, 16'h0040, 16'h0020};
  logic [1:0] sr [10] = '{1, 3, 0, 3, 3, 0, 1, 0, 2, 0};
  lrac_top #(.TICK_LEN(10)) dut (
    .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .analysis_request, .result_valid, .result_value, .flow_pulse_input,
    .sample_point_select_input, .error_in, .external_acknowledge_input,
    .analysis_go, .sample_point, .inlet_valve, .outlet_valve, .aux_relay,
    .lower_threshold_relay, .upper_threshold_relay, .lower_led_red,
    .lower_led_green, .upper_led_red, .upper_led_green, .fault_relay,
    .error_message, .first_current_output, .second_current_output
  );
  lrac_seq_model seq (
    .clk, .resetn, .analysis_go, .meas_value, .meas_delay, .result_valid,
    .result_value
  );
  // 100 MHz clock
  always #5 clk = ~clk;
  // Running activity counters; tests look only at differences
  always @(posedge clk) begin
    if (analysis_go) begin
      gos++;
      last_pt = sample_point;
    end
    if (aux_relay && !aux_d) rises++;
    aux_d = aux_relay;
    if (inlet_valve) vcyc++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus tasks leave a quiet cycle so no strobe is driven twice at one edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask
  // One request; retries follow on their own, n is the expected analyses
  task automatic meas(input logic [15:0] v, input int n);
    int g0, r0, c0;
    g0 = gos;
    r0 = rises;
    c0 = vcyc;
    meas_value <= v;
    meas_delay <= 4'(3 * n);
    analysis_request <= 1'b1;
    @(posedge clk);
    analysis_request <= 1'b0;
    repeat (150) @(posedge clk);
    aux_n = rises - r0;
    v_n = vcyc - c0;
    chk(16'(gos - g0), 16'(n));
  endtask
  task automatic rel(input logic [1:0] e);
    chk({14'h0, upper_threshold_relay, lower_threshold_relay}, {14'h0, e});
    chk({12'h0, upper_led_red, upper_led_green, lower_led_red,
      lower_led_green}, {12'h0, e[1], !e[1], e[0], !e[0]});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 4400 cycles
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    complete_run();
  end
  initial begin
    {clk, resetn, reg_wr, reg_rd, analysis_request, aux_d} = '0;
    {flow_pulse_input, sample_point_select_input} = '0;
    {external_acknowledge_input, reg_addr, reg_wdata, error_in} = '0;
    {meas_value, meas_delay} = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1 chk(16'(fault_relay), 16'h0001);
    @(posedge clk);
    rd(ADDR_CTRL, rv);
    chk(rv, 16'h2014);
    rd(ADDR_UPPER, rv);
    chk(rv, 16'h0100);
    rd(ADDR_ERR_CFG, rv);
    chk(rv, 16'hAAAA);
    rd(4'hC, rv);
    chk(rv, 16'h0000);
    wr(ADDR_UPPER, 16'h0040);
    wr(ADDR_LOWER, 16'h0050);
    rd(ADDR_LOWER, rv);
    chk(rv, 16'h003F);
    wr(ADDR_UPPER, 16'h0020);
    rd(ADDR_LOWER, rv);
    chk(rv, 16'h001F);
    wr(ADDR_LOWER, 16'h0010);
    wr(ADDR_UPPER, 16'h0030);
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_CTRL, 16'h2014 | ((i < 3) ? 16'h0 : (i < 6) ? 16'h1 : 16'h2));
      meas(sv[i], 1);
      rel(sr[i]);
    end
    chk(16'(fault_relay), 16'h0001);
    $display("test modes done");
    wr(ADDR_CTRL, 16'h2078);
    meas(16'h0040, 3);
    chk(16'(aux_n), 16'h0000);
    rel(2'b11);
    meas(16'h0040, 1);
    meas(16'h0005, 1);
    rel(2'b00);
    wr(ADDR_AUX_TIME, 16'h0001);
    meas(16'h0040, 3);
    chk(16'(aux_n), 16'h0002);
    meas(16'h0005, 1);
    for (int m = 0; m < 6; m++) begin
      wr(ADDR_CTRL, 16'h2014 | 16'(m << 6));
      meas(16'h0005, 1);
      chk(16'(aux_n != 0), 16'(m >= 2));
    end
    wr(ADDR_AUX_TIME, 16'h0000);
    wr(ADDR_FLUSH_TIME, 16'h0002);
    meas(16'h0005, 1);
    chk(16'(v_n >= 20), 16'h0001);
    wr(ADDR_FLUSH_TIME, 16'h0000);
    $display("test counts aux flush done");
    wr(ADDR_CTRL, 16'h2014);
    meas(16'h0123, 1);
    chk(16'(last_pt), 16'h0000);
    chk(first_current_output, 16'h0123);
    wr(ADDR_CTRL, 16'h2214);
    meas(16'h0005, 1);
    p = last_pt;
    meas(16'h0005, 1);
    chk(16'(last_pt), 16'(!p));
    wr(ADDR_CTRL, 16'h2414);
    for (int s = 1; s >= 0; s--) begin
      sample_point_select_input <= 1'(s);
      meas(16'h0005, 1);
      chk(16'(last_pt), 16'(s));
      chk(s ? second_current_output : first_current_output, 16'h0005);
    end
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_CTRL, 16'h0014 | 16'(i << 11));
      wr(ADDR_FLOW_LO, 16'h0000);
      repeat (2) begin
        flow_pulse_input <= 1'b1;
        repeat (3) @(posedge clk);
        flow_pulse_input <= 1'b0;
        repeat (3) @(posedge clk);
      end
      rd(ADDR_FLOW_LO, rv);
      chk(rv, 16'(2 * kpp[i]));
    end
    $display("test points and meter done");
    for (int k = 0; k < 2; k++) begin
      error_in <= 8'h01;
      repeat (8) @(posedge clk);
      chk(16'({fault_relay, error_message}), 16'h0001);
      repeat (20) @(posedge clk);
      chk(16'(fault_relay), 16'h0000);
      if (k == 0) begin
        external_acknowledge_input <= 1'b1;
        repeat (4) @(posedge clk);
        external_acknowledge_input <= 1'b0;
      end else begin
        wr(ADDR_CMD, 16'h0001);
      end
      repeat (4) @(posedge clk);
      chk(16'(fault_relay), 16'h0001);
      error_in <= 8'h00;
      repeat (4) @(posedge clk);
    end
    for (int k = 1; k >= 0; k--) begin
      wr(ADDR_ERR_CFG, 16'hAAA8 | 16'(k));
      error_in <= 8'h01;
      repeat (8) @(posedge clk);
      chk(16'({fault_relay, error_message}), 16'(2 + k));
      error_in <= 8'h00;
      repeat (4) @(posedge clk);
    end
    $display("test errors done");
    complete_run();
  end
endmodule
`default_nettype wire
